// ### rtl/isq_pkg.sv
/*
  constants shared by the instruction sequencer: widths, reset values,
  special data addresses, instruction encodings and the decode classes.
  assumes nothing of its surroundings.
*/
package isq_pkg;

  localparam int PC_W  = 10;
  localparam int STK_W = 12;
  localparam int DAT_W = 8;
  localparam int FA_W  = 5;
  localparam int IR_W  = 12;

  localparam logic [PC_W-1:0]  PC_RST     = 10'h3FF;
  localparam logic [STK_W-1:0] STK_RST    = 12'h000;
  localparam logic [IR_W-1:0]  IR_RST     = 12'h000;
  localparam logic [DAT_W-1:0] STATUS_RST = 8'h00;
  localparam logic [DAT_W-1:0] W_RST      = 8'h00;
  localparam logic [3:0]       PHASE_RST  = 4'h1;

  // data addresses served inside this block
  localparam logic [FA_W-1:0] ADDR_PCL    = 5'h02;
  localparam logic [FA_W-1:0] ADDR_STATUS = 5'h03;
  localparam int              PAGE_BIT    = 5;

  // opcode fields, compared against the top bits of the word
  localparam logic [2:0] OPC_JUMP   = 3'h5;
  localparam logic [3:0] OPC_CALL   = 4'h9;
  localparam logic [3:0] OPC_RETLIT = 4'h8;
  localparam logic [3:0] OPC_MOVLIT = 4'hC;
  localparam logic [3:0] OPC_BSET   = 4'h5;
  localparam logic [6:0] OPC_MOVWF  = 7'h01;
  localparam logic [5:0] OPC_ADDWF  = 6'h07;

  typedef enum logic [2:0] {
    OP_NOP, OP_JUMP, OP_CALL, OP_RETLIT, OP_MOVLIT, OP_MOVWF, OP_ADDWF,
    OP_BSET
  } isq_op_e;

endpackage

// ### rtl/isq_stk_if.sv
/*
  interface between the sequencer and its return-address stack.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface isq_stk_if;
  logic                      push;
  logic                      pop;
  logic [isq_pkg::STK_W-1:0] push_data;
  logic [isq_pkg::STK_W-1:0] top;
  modport ctl (output push, output pop, output push_data, input top);
  modport stk (input push, input pop, input push_data, output top);
endinterface
`default_nettype wire

// ### rtl/isq_stack.sv
/*
  two-level return-address stack.
  assumes push and pop are one-cycle pulses, never both at once.
*/
`timescale 1ns/1ps
`default_nettype none
module isq_stack (
  // clock and reset
  input  wire logic  clock,
  input  wire logic  rst_n,
  // stack port
  isq_stk_if.stk     stk
);

  logic [isq_pkg::STK_W-1:0] lvl1_r;
  logic [isq_pkg::STK_W-1:0] lvl2_r;

  // no overflow or underflow flag exists; excess pushes drop the oldest
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lvl1_r <= isq_pkg::STK_RST;
      lvl2_r <= isq_pkg::STK_RST;
    end else if (stk.push) begin
      lvl2_r <= lvl1_r;
      lvl1_r <= stk.push_data;
    end else if (stk.pop) begin
      lvl1_r <= lvl2_r;
    end
  end

  assign stk.top = lvl1_r;

  push_order_a: assert property (@(posedge clock) disable iff (!rst_n)
    stk.push |=> lvl2_r == $past(lvl1_r) && lvl1_r == $past(stk.push_data))
    else $error("push did not shift level one into level two");

  pop_refill_a: assert property (@(posedge clock) disable iff (!rst_n)
    stk.pop && !stk.push |=> lvl1_r == $past(lvl2_r) && $stable(lvl2_r))
    else $error("pop did not copy level two into level one");

endmodule // isq_stack
`default_nettype wire

// ### rtl/isq_top.sv
/*
  instruction sequencer: four-phase clock divider, fetch/execute pipeline,
  program counter with paging and the return-address stack.
  assumes program memory answers prog_data for prog_addr_r within a phase
  and data memory answers dmem_rdata while dmem_rd_r is high.
*/
// Functional notes
// - the clock is divided by four into four one-hot phases per cycle.
// - the counter advances in phase one and the word is latched in four.
// - a word fetched in one cycle executes in the next one.
// - a counter-changing instruction discards the next fetched word.
// - operands are read in phase two and results written in phase four.
// - a jump loads counter bits 8..0 from the word, bit 9 from status 5.
// - the low count byte in data space reflects fetch address bits 7..0.
// - a call or low count byte write loads bits 7..0 and clears bit 8.
// - reset sets the counter to the last address, which then wraps to 0.
// - reset clears the page preselect bits of the status register.
// - a two-deep stack of twelve-bit return addresses is provided.
// - a call pushes level one to level two, then the next address.
// - a return pops level one to the counter, then copies level two up.
// - a return also loads the accumulator with its literal.
// - stack overflow and underflow are silent, with no status flag.
`timescale 1ns/1ps
`default_nettype none
module isq_top (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       nrst,
  // phase clocks
  output var  logic                       phase_one_r,
  output var  logic                       phase_two_r,
  output var  logic                       phase_three_r,
  output var  logic                       phase_four_r,
  // program memory
  output var  logic [isq_pkg::PC_W-1:0]   prog_addr_r,
  input  wire logic [isq_pkg::IR_W-1:0]   prog_data,
  // data memory
  output var  logic [isq_pkg::FA_W-1:0]   dmem_addr_r,
  output var  logic                       dmem_rd_r,
  input  wire logic [isq_pkg::DAT_W-1:0]  dmem_rdata,
  output var  logic                       dmem_wr_r,
  output var  logic [isq_pkg::DAT_W-1:0]  dmem_wdata_r,
  // core state
  output var  logic [isq_pkg::DAT_W-1:0]  accum_r,
  output var  logic [isq_pkg::DAT_W-1:0]  status_r
);

  // ----------------------------------------------------------------------
  // reset release and decode helpers
  // ----------------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n;
  logic chk_en_r;

  // checks start one edge after the internal reset lifts
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
      chk_en_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
      chk_en_r <= rst_n;
    end
  end

  function automatic isq_pkg::isq_op_e op_of(
    input logic [isq_pkg::IR_W-1:0] w);
    isq_pkg::isq_op_e op;
    op = isq_pkg::OP_NOP;
    if (w[11:9] == isq_pkg::OPC_JUMP)        op = isq_pkg::OP_JUMP;
    else if (w[11:8] == isq_pkg::OPC_CALL)   op = isq_pkg::OP_CALL;
    else if (w[11:8] == isq_pkg::OPC_RETLIT) op = isq_pkg::OP_RETLIT;
    else if (w[11:8] == isq_pkg::OPC_MOVLIT) op = isq_pkg::OP_MOVLIT;
    else if (w[11:8] == isq_pkg::OPC_BSET)   op = isq_pkg::OP_BSET;
    else if (w[11:5] == isq_pkg::OPC_MOVWF)  op = isq_pkg::OP_MOVWF;
    else if (w[11:6] == isq_pkg::OPC_ADDWF)  op = isq_pkg::OP_ADDWF;
    return op;
  endfunction

  function automatic logic reads_file(input isq_pkg::isq_op_e op);
    return op == isq_pkg::OP_ADDWF || op == isq_pkg::OP_BSET;
  endfunction

  // low count byte and status live here and never reach data memory
  function automatic logic served_inside(
    input logic [isq_pkg::FA_W-1:0] f);
    return f == isq_pkg::ADDR_PCL || f == isq_pkg::ADDR_STATUS;
  endfunction

  // ----------------------------------------------------------------------
  // phase generation
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {phase_four_r, phase_three_r, phase_two_r, phase_one_r}
        <= isq_pkg::PHASE_RST;
    end else begin
      phase_one_r   <= phase_four_r;
      phase_two_r   <= phase_one_r;
      phase_three_r <= phase_two_r;
      phase_four_r  <= phase_three_r;
    end
  end

  // ----------------------------------------------------------------------
  // pipeline registers and decode
  // ----------------------------------------------------------------------
  logic [isq_pkg::IR_W-1:0]  instr_latch_r;
  logic                      fetch_v_r;
  logic [isq_pkg::IR_W-1:0]  exec_r;
  logic                      exec_v_r;
  logic [isq_pkg::DAT_W-1:0] operand_r;
  logic [isq_pkg::PC_W-1:0]  pc_r;
  isq_pkg::isq_op_e          ex_op;
  logic [isq_pkg::FA_W-1:0]  ex_f;
  logic [isq_pkg::DAT_W-1:0] result;
  logic                      dest_f;
  logic                      pcl_wr;
  logic                      branch;
  logic                      page;
  isq_stk_if                 stk ();

  assign ex_op = op_of(exec_r);
  assign ex_f  = exec_r[4:0];
  assign page  = status_r[isq_pkg::PAGE_BIT];

  always_comb begin
    result = accum_r;
    dest_f = 1'b0;
    case (ex_op)
      isq_pkg::OP_MOVWF: begin
        result = accum_r;
        dest_f = 1'b1;
      end
      isq_pkg::OP_ADDWF: begin
        result = operand_r + accum_r;
        dest_f = exec_r[5];
      end
      isq_pkg::OP_BSET: begin
        result = operand_r | (8'h01 << exec_r[7:5]);
        dest_f = 1'b1;
      end
      default: begin
        result = accum_r;
        dest_f = 1'b0;
      end
    endcase
  end

  assign pcl_wr = dest_f && ex_f == isq_pkg::ADDR_PCL;
  assign branch = exec_v_r && (pcl_wr || ex_op == isq_pkg::OP_JUMP ||
                  ex_op == isq_pkg::OP_CALL || ex_op == isq_pkg::OP_RETLIT);

  // word latched in phase four, handed to execute in phase one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      instr_latch_r <= isq_pkg::IR_RST;
      fetch_v_r     <= 1'b0;
      exec_r        <= isq_pkg::IR_RST;
      exec_v_r      <= 1'b0;
    end else if (phase_one_r) begin
      exec_r   <= instr_latch_r;
      exec_v_r <= fetch_v_r;
    end else if (phase_four_r) begin
      instr_latch_r <= prog_data;
      fetch_v_r     <= !branch;
    end
  end

  // ----------------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_r        <= isq_pkg::PC_RST;
      prog_addr_r <= isq_pkg::PC_RST;
    end else if (phase_one_r) begin
      prog_addr_r <= pc_r;
      pc_r        <= pc_r + 10'h001;
    end else if (phase_four_r && exec_v_r) begin
      if (ex_op == isq_pkg::OP_JUMP)
        pc_r <= {page, exec_r[8:0]};
      else if (ex_op == isq_pkg::OP_CALL)
        pc_r <= {page, 1'b0, exec_r[7:0]};
      else if (ex_op == isq_pkg::OP_RETLIT)
        pc_r <= stk.top[isq_pkg::PC_W-1:0];
      else if (pcl_wr)
        pc_r <= {page, 1'b0, result};
    end
  end

  assign stk.push      = phase_four_r && exec_v_r &&
                         ex_op == isq_pkg::OP_CALL;
  assign stk.pop       = phase_four_r && exec_v_r &&
                         ex_op == isq_pkg::OP_RETLIT;
  assign stk.push_data = {2'b00, prog_addr_r};

  isq_stack u_stack (
    .clock (clock),
    .rst_n (rst_n),
    .stk   (stk)
  );

  // ----------------------------------------------------------------------
  // data memory access
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dmem_addr_r  <= '0;
      dmem_rd_r    <= 1'b0;
      dmem_wr_r    <= 1'b0;
      dmem_wdata_r <= '0;
      operand_r    <= '0;
    end else begin
      dmem_rd_r <= 1'b0;
      dmem_wr_r <= 1'b0;
      if (phase_one_r) begin
        dmem_addr_r <= instr_latch_r[4:0];
        dmem_rd_r   <= fetch_v_r && reads_file(op_of(instr_latch_r)) &&
                       !served_inside(instr_latch_r[4:0]);
      end
      if (phase_two_r) begin
        if (ex_f == isq_pkg::ADDR_PCL)
          operand_r <= prog_addr_r[7:0];
        else if (ex_f == isq_pkg::ADDR_STATUS)
          operand_r <= status_r;
        else
          operand_r <= dmem_rdata;
      end
      if (phase_three_r && exec_v_r && dest_f && !served_inside(ex_f)) begin
        dmem_wr_r    <= 1'b1;
        dmem_wdata_r <= result;
      end
    end
  end

  // ----------------------------------------------------------------------
  // accumulator and status
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      accum_r  <= isq_pkg::W_RST;
      status_r <= isq_pkg::STATUS_RST;
    end else if (phase_four_r && exec_v_r) begin
      if (ex_op == isq_pkg::OP_RETLIT || ex_op == isq_pkg::OP_MOVLIT)
        accum_r <= exec_r[7:0];
      else if (ex_op == isq_pkg::OP_ADDWF && !dest_f)
        accum_r <= result;
      if (dest_f && ex_f == isq_pkg::ADDR_STATUS)
        status_r <= result;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!chk_en_r);

  sequence phase_walk_s;
    phase_two_r ##1 phase_three_r ##1 phase_four_r ##1 phase_one_r;
  endsequence

  phase_rotate_a: assert property (phase_one_r |=> phase_walk_s)
    else $error("phases did not rotate in order");
  fetch_addr_a: assert property (!phase_one_r |=> $stable(prog_addr_r))
    else $error("fetch address moved outside phase one");
  latch_phase_a: assert property ($changed(instr_latch_r) |->
    $past(phase_four_r)) else $error("word latched outside phase four");
  exec_follow_a: assert property (phase_one_r |=>
    exec_v_r == $past(fetch_v_r)) else $error("fetched word not executed");
  branch_flush_a: assert property (phase_four_r && branch |=>
    !fetch_v_r ##1 phase_walk_s ##0 !exec_v_r)
    else $error("word after a branch was not discarded");
  read_phase_a: assert property (dmem_rd_r |-> phase_two_r)
    else $error("operand read outside phase two");
  write_phase_a: assert property (dmem_wr_r |-> phase_four_r)
    else $error("destination write outside phase four");
  inside_addr_a: assert property (dmem_rd_r |->
    !served_inside(dmem_addr_r)) else $error("internal address strobed");
  jump_load_a: assert property (phase_four_r && exec_v_r &&
    ex_op == isq_pkg::OP_JUMP |=> pc_r == {$past(page), $past(exec_r[8:0])})
    else $error("jump target wrong");
  call_page_a: assert property (phase_four_r && exec_v_r &&
    (ex_op == isq_pkg::OP_CALL || pcl_wr) |=> !pc_r[8])
    else $error("counter bit 8 not cleared");
  retlit_acc_a: assert property (stk.pop |=>
    accum_r == $past(exec_r[7:0])) else $error("return literal not loaded");

endmodule // isq_top
`default_nettype wire

// ### bench/isq_mem_model.sv
/*
  program and data memory model facing the instruction sequencer.
  assumes the bench loads rom and clears ram while reset is held.
*/
`timescale 1ns/1ps
`default_nettype none
module isq_mem_model (
  // clock and phases
  input  wire logic                      clock,
  input  wire logic                      phase_two_r,
  input  wire logic                      phase_four_r,
  // program memory
  input  wire logic [isq_pkg::PC_W-1:0]  prog_addr_r,
  output var  logic [isq_pkg::IR_W-1:0]  prog_data,
  // data memory
  input  wire logic [isq_pkg::FA_W-1:0]  dmem_addr_r,
  input  wire logic                      dmem_rd_r,
  output var  logic [isq_pkg::DAT_W-1:0] dmem_rdata,
  input  wire logic                      dmem_wr_r,
  input  wire logic [isq_pkg::DAT_W-1:0] dmem_wdata_r
);
  logic [11:0] rom [0:1023];
  logic [7:0]  ram [0:31];
  logic [7:0]  last_r = 8'h00;
  int          rd_cnt = 0;
  int          wr_cnt = 0;
  int          bad = 0;

  assign prog_data = rom[prog_addr_r];
  // a released data bus shows the inverse of its last value
  assign dmem_rdata = dmem_rd_r ? ram[dmem_addr_r] : ~last_r;

  // strobes out of phase or at internally served addresses are counted
  always @(posedge clock) begin
    if (dmem_rd_r) begin
      last_r <= ram[dmem_addr_r];
      rd_cnt++;
    end
    if (dmem_wr_r) begin
      ram[dmem_addr_r] <= dmem_wdata_r;
      wr_cnt++;
    end
    if ((dmem_rd_r && !phase_two_r) || (dmem_wr_r && !phase_four_r))
      bad++;
    if ((dmem_rd_r || dmem_wr_r) && dmem_addr_r inside {5'h02, 5'h03})
      bad++;
  end
endmodule // isq_mem_model
`default_nettype wire

// ### bench/tb_top.sv
/*
  self-checking bench for the instruction sequencer.
  assumes the memory model answers fetches and data accesses.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                      clock;
  logic                      nrst;
  logic                      phase_one_r;
  logic                      phase_two_r;
  logic                      phase_three_r;
  logic                      phase_four_r;
  logic [isq_pkg::PC_W-1:0]  prog_addr_r;
  logic [isq_pkg::IR_W-1:0]  prog_data;
  logic [isq_pkg::FA_W-1:0]  dmem_addr_r;
  logic                      dmem_rd_r;
  logic [isq_pkg::DAT_W-1:0] dmem_rdata;
  logic                      dmem_wr_r;
  logic [isq_pkg::DAT_W-1:0] dmem_wdata_r;
  logic [isq_pkg::DAT_W-1:0] accum_r;
  logic [isq_pkg::DAT_W-1:0] status_r;
  int                        mismatches = 0;
  int                        cmp_count = 0;
  int                        cycles = 0;
  logic [9:0]                at [0:31];
  logic [7:0]                ac [0:31];
  logic [7:0]                sr [0:31];
  logic [9:0]                ea [$];
  logic [7:0]                ec [$];

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  isq_top u_dut (.clock(clock), .nrst(nrst), .phase_one_r(phase_one_r),
    .phase_two_r(phase_two_r), .phase_three_r(phase_three_r),
    .phase_four_r(phase_four_r), .prog_addr_r(prog_addr_r),
    .prog_data(prog_data), .dmem_addr_r(dmem_addr_r), .dmem_rd_r(dmem_rd_r),
    .dmem_rdata(dmem_rdata), .dmem_wr_r(dmem_wr_r),
    .dmem_wdata_r(dmem_wdata_r), .accum_r(accum_r), .status_r(status_r));

  isq_mem_model u_mem (.clock(clock), .phase_two_r(phase_two_r),
    .phase_four_r(phase_four_r), .prog_addr_r(prog_addr_r),
    .prog_data(prog_data), .dmem_addr_r(dmem_addr_r), .dmem_rd_r(dmem_rd_r),
    .dmem_rdata(dmem_rdata), .dmem_wr_r(dmem_wr_r),
    .dmem_wdata_r(dmem_wdata_r));

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [11:0] exp,
                     input logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // clear memories and hold reset
  task automatic hold();
    @(negedge clock);
    nrst = 1'b0;
    for (int i = 0; i < 1024; i++) u_mem.rom[i] = 12'h000;
    for (int i = 0; i < 32; i++) u_mem.ram[i] = 8'h00;
    u_mem.rd_cnt = 0;
    u_mem.wr_cnt = 0;
    u_mem.bad = 0;
  endtask

  // release reset, trace one sample per cycle in phase two, compare
  task automatic go();
    logic [3:0] ph;
    repeat (12) @(negedge clock);
    chk("reset addr", 12'h3FF, {2'b00, prog_addr_r});
    chk("reset status", 12'h000, {4'h0, status_r});
    nrst = 1'b1;
    @(negedge clock iff phase_two_r === 1'b1);
    ph = 4'b0010;
    for (int i = 0; i < ea.size(); i++) begin
      at[i] = prog_addr_r;
      ac[i] = accum_r;
      sr[i] = status_r;
      for (int k = 0; k < 4; k++) begin
        chk("phase", {8'h00, ph}, {8'h00, phase_four_r, phase_three_r,
            phase_two_r, phase_one_r});
        ph = {ph[2:0], ph[3]};
        @(negedge clock);
      end
    end
    for (int i = 0; i < ea.size(); i++) begin
      chk("fetch addr", {2'b00, ea[i]}, {2'b00, at[i]});
      chk("accum", {4'h0, ec[i]}, {4'h0, ac[i]});
    end
    chk("strobe faults", 12'h000, 12'(u_mem.bad));
  endtask

  //--------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------
  task automatic t_jump();
    hold();
    u_mem.rom[10'h3FF] = 12'hC5A;
    u_mem.rom[10'h000] = 12'hA05;
    u_mem.rom[10'h001] = 12'hC11;
    u_mem.rom[10'h005] = 12'hC22;
    ea = '{10'h3FF, 10'h000, 10'h001, 10'h005, 10'h006, 10'h007};
    ec = '{8'h00, 8'h00, 8'h5A, 8'h5A, 8'h5A, 8'h22};
    go();
    $display("test jump and flush done, mismatches %0d", mismatches);
  endtask

  task automatic t_stack();
    hold();
    u_mem.rom[10'h000] = 12'h5A3;
    u_mem.rom[10'h001] = 12'hA10;
    u_mem.rom[10'h210] = 12'h930;
    u_mem.rom[10'h230] = 12'h940;
    u_mem.rom[10'h240] = 12'h950;
    u_mem.rom[10'h250] = 12'h801;
    u_mem.rom[10'h241] = 12'h802;
    u_mem.rom[10'h231] = 12'h803;
    ea = '{10'h3FF, 10'h000, 10'h001, 10'h002, 10'h210, 10'h211, 10'h230,
           10'h231, 10'h240, 10'h241, 10'h250, 10'h251, 10'h241, 10'h242,
           10'h231, 10'h232, 10'h231, 10'h232};
    ec = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
           8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h02, 8'h02, 8'h03, 8'h03};
    go();
    chk("page bit", 12'h020, {4'h0, sr[3]});
    $display("test call and return done, mismatches %0d", mismatches);
  endtask

  task automatic t_pcl();
    hold();
    u_mem.rom[10'h3FF] = 12'hC10;
    u_mem.rom[10'h000] = 12'hB80;
    u_mem.rom[10'h180] = 12'h022;
    u_mem.rom[10'h010] = 12'h02A;
    u_mem.rom[10'h011] = 12'h1CA;
    u_mem.rom[10'h012] = 12'h1E2;
    u_mem.rom[10'h033] = 12'h5C2;
    ea = '{10'h3FF, 10'h000, 10'h001, 10'h180, 10'h181, 10'h010, 10'h011,
           10'h012, 10'h013, 10'h033, 10'h034, 10'h074};
    ec = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h20,
           8'h20, 8'h20, 8'h20};
    go();
    chk("ram write", 12'h010, {4'h0, u_mem.ram[5'h0A]});
    chk("read count", 12'h001, 12'(u_mem.rd_cnt));
    chk("write count", 12'h001, 12'(u_mem.wr_cnt));
    $display("test low count byte done, mismatches %0d", mismatches);
  endtask

  initial begin
    nrst = 1'b0;
    t_jump();
    t_stack();
    t_pcl();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
